// *** bench/testbench.sv ***
// Self-checking bench of the timer interrupt block
`include "tmi_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_MASK = `TMI_ADDR_OF(`TMI_IDX_MASK);
    localparam logic [7:0] A_FLAG = `TMI_ADDR_OF(`TMI_IDX_FLAGS);
    localparam logic [7:0] A_CMPB = `TMI_ADDR_OF(`TMI_IDX_CMPB);
    localparam logic [7:0] OVF_CV [8] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h3C};
    localparam logic [2:0] OVF_EXP [8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h0, 3'h3};
    logic              i_clk = 1'b0;
    logic              i_rstn = 1'b0;
    logic              psel = 1'b0;
    logic              pen = 1'b0;
    logic              pwr = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata, rd;
    logic              pready, pslverr, er, irq, mb, ma, ms;
    logic              gie = 1'b0;
    logic              take = 1'b0;
    logic [3:0]        dly = 4'h0;
    tmi_pkg::tmi_cnt_t cnt = '0;
    tmi_pkg::tmi_src_t req, vec;
    int                bad_count = 0;
    int                comparisons = 0;
    int                cyc = 0;

    tmi_timer_irq dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_cnt(cnt), .i_global_irq_en(gie),
        .i_vector_taken(vec), .o_irq_req(req), .o_irq(irq), .o_compare_b_match(mb),
        .o_compare_a_match(ma));
    tmi_core_model core (.i_clk(i_clk), .i_rstn(i_rstn), .i_irq_req(req), .i_take_en(take),
        .i_delay(dly), .o_vector_taken(vec));

    // Clock and cycle ceiling
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic check_bit(input string nm, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        paddr <= a;
        pwr <= w;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // One counter-side cycle, then settle; ms holds the B match pulse
    task automatic ev(input logic [2:0] m, input logic [7:0] v, input logic wr, input logic tk,
                      input logic frc);
        @(posedge i_clk);
        cnt.wave_gen_mode <= m;
        cnt.counter_value <= v;
        cnt.counter_written <= wr;
        cnt.tick <= tk;
        cnt.force_compare_b <= frc;
        @(posedge i_clk);
        cnt.tick <= 1'b0;
        cnt.counter_written <= 1'b0;
        cnt.force_compare_b <= 1'b0;
        #1 ms = mb;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic wait_low();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge i_clk);
            n++;
        end
        check_bit("irq high", 1'b1, irq);
        while (irq !== 1'b0 && n < 60) begin
            @(posedge i_clk);
            n++;
        end
        check_bit("irq low", 1'b0, irq);
    endtask

    initial begin
        cnt.compare_a_value = 8'h3C;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        apb(A_MASK, 1'b0, 32'h0);
        check_reg("mask", 32'h0, rd);
        apb(A_MASK, 1'b1, 32'hFF);
        apb(A_MASK, 1'b0, 32'h0);
        check_reg("mask", 32'h7, rd);
        apb(A_CMPB, 1'b1, 32'hA5);
        apb(A_CMPB, 1'b0, 32'h0);
        check_reg("compare b", 32'hA5, rd);
        apb(8'hFC, 1'b0, 32'h0);
        check_bit("slverr", 1'b1, er);
        apb(A_MASK, 1'b1, 32'h3);
        for (int m = 0; m < 8; m++) begin
            ev(m[2:0], OVF_CV[m], 1'b0, 1'b1, 1'b0);
            apb(A_FLAG, 1'b0, 32'h0);
            check_reg("flags", {29'h0, OVF_EXP[m]}, rd);
            apb(A_FLAG, 1'b1, 32'h7);
            apb(A_FLAG, 1'b0, 32'h0);
            check_reg("flags", 32'h0, rd);
        end
        ev(3'h0, 8'hA5, 1'b1, 1'b0, 1'b0);
        ev(3'h0, 8'hA5, 1'b0, 1'b1, 1'b0);
        check_bit("b match", 1'b0, ms);
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h0, rd);
        ev(3'h0, 8'hA5, 1'b0, 1'b1, 1'b0);
        check_bit("b match", 1'b1, ms);
        apb(A_FLAG, 1'b1, 32'hF8);
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h4, rd);
        apb(A_FLAG, 1'b1, 32'h4);
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h0, rd);
        ev(3'h0, 8'h10, 1'b0, 1'b0, 1'b1);
        check_bit("b match", 1'b1, ms);
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h0, rd);
        gie <= 1'b1;
        apb(A_MASK, 1'b1, 32'h7);
        ev(3'h0, 8'hA5, 1'b0, 1'b1, 1'b0);
        check_reg("requests", 32'h4, {29'h0, req});
        take <= 1'b1;
        wait_low();
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h0, rd);
        dly <= 4'h5;
        gie <= 1'b0;
        ev(3'h0, 8'h3C, 1'b0, 1'b1, 1'b0);
        check_reg("requests", 32'h0, {29'h0, req});
        check_bit("irq", 1'b1, irq);
        gie <= 1'b1;
        wait_low();
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h0, rd);
        apb(A_MASK, 1'b1, 32'h0);
        ev(3'h0, 8'hFF, 1'b0, 1'b1, 1'b0);
        check_reg("requests", 32'h0, {29'h0, req});
        apb(A_MASK, 1'b1, 32'h1);
        wait_low();
        apb(A_FLAG, 1'b0, 32'h0);
        check_reg("flags", 32'h0, rd);
        final_report();
    end
endmodule

// *** bench/tmi_core_model.sv ***
// Behavioural processor core that takes the timer interrupt vectors
module tmi_core_model (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire tmi_pkg::tmi_src_t i_irq_req,
    input  wire logic              i_take_en,
    input  wire logic [3:0]        i_delay,
    output tmi_pkg::tmi_src_t      o_vector_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    logic [1:0] hold;

    // Waits i_delay cycles on a request, pulses the vector once, then lets the request fall
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_vector_taken <= '0;
            wait_cnt <= 4'h0;
            hold <= 2'h0;
        end else if (hold != 2'h0) begin
            o_vector_taken <= '0;
            hold <= hold - 2'h1;
        end else if (i_take_en && (|i_irq_req) && wait_cnt >= i_delay) begin
            o_vector_taken <= i_irq_req;
            hold <= 2'h3;
            wait_cnt <= 4'h0;
        end else if (i_take_en && (|i_irq_req)) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// *** bench/tmi_props.sv ***
// Checker of interrupt, match and register read behaviour of the timer interrupt block
`include "tmi_map.svh"

module tmi_props (
    input wire logic              i_clk,
    input wire logic              i_rstn,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [7:0]        i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic [3:0]        i_pstrb,
    input wire logic              o_pready,
    input wire logic [31:0]       o_prdata,
    input wire tmi_pkg::tmi_cnt_t i_cnt,
    input wire logic              i_global_irq_en,
    input wire tmi_pkg::tmi_src_t i_vector_taken,
    input wire tmi_pkg::tmi_src_t o_irq_req,
    input wire logic              o_irq,
    input wire logic              o_compare_b_match,
    input wire logic              o_compare_a_match
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    logic [2:0] mask_sh;
    logic       armed;
    logic       ovf_hit;
    logic       blk;
    logic       a_hit;

    // Shadow of the mask register, updated on a completed write
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mask_sh <= 3'h0;
        end else if (i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
                     && i_paddr == `TMI_ADDR_OF(`TMI_IDX_MASK)) begin
            mask_sh <= i_pwdata[2:0];
        end
    end

    // Match suppression armed by a counter write until the next tick
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            armed <= 1'b0;
        end else begin
            armed <= i_cnt.counter_written | (armed & ~i_cnt.tick);
        end
    end

    // Overflow point of each mode
    always_comb begin
        case (i_cnt.wave_gen_mode)
            `TMI_WGM_NORMAL, `TMI_WGM_CTC, `TMI_WGM_FAST_FIXED:
                ovf_hit = i_cnt.counter_value == `TMI_CNT_MAX;
            `TMI_WGM_PC_FIXED, `TMI_WGM_PC_VAR:
                ovf_hit = i_cnt.counter_value == `TMI_CNT_BOTTOM;
            `TMI_WGM_FAST_VAR:
                ovf_hit = i_cnt.counter_value == i_cnt.compare_a_value;
            default:
                ovf_hit = 1'b0;
        endcase
    end

    // Unsuppressed compare A hit on a tick
    assign blk   = armed | i_cnt.counter_written;
    assign a_hit = i_cnt.tick & ~blk & (i_cnt.counter_value == i_cnt.compare_a_value);

    sequence s_ovf;
        i_cnt.tick && ovf_hit ##1 mask_sh[0];
    endsequence
    sequence s_cmpa;
        a_hit ##1 mask_sh[1];
    endsequence

    AST_RSV_ZERO: assert property (
        o_pready && (i_paddr == 8'hE0 || i_paddr == 8'hE4) |-> o_prdata[31:3] == 29'h0)
        else $error("reserved bits read non-zero");
    AST_REQ_B: assert property (
        o_irq_req.cmp_b |-> $past(i_global_irq_en) && $past(mask_sh[2]) && o_irq)
        else $error("compare B request without its enables");
    AST_REQ_A: assert property (
        o_irq_req.cmp_a |-> $past(i_global_irq_en) && $past(mask_sh[1]) && o_irq)
        else $error("compare A request without its enables");
    AST_REQ_OVF: assert property (
        o_irq_req.ovf |-> $past(i_global_irq_en) && $past(mask_sh[0]) && o_irq)
        else $error("overflow request without its enables");
    AST_OVF_SET: assert property (
        s_ovf |=> o_irq)
        else $error("overflow point did not raise the interrupt");
    AST_CMPA_SET: assert property (
        s_cmpa |=> o_irq)
        else $error("compare A hit did not raise the interrupt");
    AST_CMPA_MATCH: assert property (
        a_hit |=> o_compare_a_match)
        else $error("compare A match pulse missing");
    AST_SUPPRESS: assert property (
        i_cnt.tick && blk && !i_cnt.force_compare_b |=> !o_compare_a_match && !o_compare_b_match)
        else $error("match after a counter write");
    AST_FORCE: assert property (
        i_cnt.force_compare_b && (i_cnt.wave_gen_mode == `TMI_WGM_NORMAL
        || i_cnt.wave_gen_mode == `TMI_WGM_CTC) |=> o_compare_b_match)
        else $error("forced compare gave no match pulse");
    AST_VEC_B: assert property (
        i_vector_taken.cmp_b && !i_cnt.tick |-> ##2 !o_irq_req.cmp_b)
        else $error("compare B flag kept after its vector");
    AST_VEC_A: assert property (
        i_vector_taken.cmp_a && !i_cnt.tick |-> ##2 !o_irq_req.cmp_a)
        else $error("compare A flag kept after its vector");
    AST_VEC_OVF: assert property (
        i_vector_taken.ovf && !i_cnt.tick |-> ##2 !o_irq_req.ovf)
        else $error("overflow flag kept after its vector");
endmodule

bind tmi_timer_irq tmi_props u_props (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .i_cnt, .i_global_irq_en,
    .i_vector_taken, .o_irq_req, .o_irq, .o_compare_b_match, .o_compare_a_match);

// *** core/tmi_flag_cell.sv ***
// Sticky event flag with a clear input, where a set beats a clear
module tmi_flag_cell (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);

    logic flag_reg;
    logic flag_next;

    // Set wins over clear so an event is never lost
    always_comb begin
        flag_next = flag_reg;
        if (i_clr) begin
            flag_next = 1'b0;
        end
        if (i_set) begin
            flag_next = 1'b1;
        end
    end

    // Flag storage
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flag = flag_reg;

endmodule

// *** core/tmi_map.svh ***
// Register map, field positions, reset values and mode codes of the timer interrupt block
`ifndef TMI_MAP_SVH
`define TMI_MAP_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------
`define TMI_IDX_FLAGS      8'h38
`define TMI_IDX_MASK       8'h39
`define TMI_IDX_CMPB       8'h3C
`define TMI_ADDR_OF(idx)   (8'((idx) * 4))

// ----------------------------------------------------------------
// Field positions in mask and flag registers
// ----------------------------------------------------------------
`define TMI_BIT_OVF        0
`define TMI_BIT_CMPA       1
`define TMI_BIT_CMPB       2
`define TMI_NUM_SRC        3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMI_RST_MASK       3'h0
`define TMI_RST_FLAGS      3'h0
`define TMI_RST_CMPB       8'h00

// ----------------------------------------------------------------
// Counter landmarks
// ----------------------------------------------------------------
`define TMI_CNT_MAX        8'hFF
`define TMI_CNT_BOTTOM     8'h00

// ----------------------------------------------------------------
// Waveform generation mode codes
// ----------------------------------------------------------------
`define TMI_WGM_NORMAL     3'h0
`define TMI_WGM_PC_FIXED   3'h1
`define TMI_WGM_CTC        3'h2
`define TMI_WGM_FAST_FIXED 3'h3
`define TMI_WGM_RSVD4      3'h4
`define TMI_WGM_PC_VAR     3'h5
`define TMI_WGM_RSVD6      3'h6
`define TMI_WGM_FAST_VAR   3'h7

`endif

// *** core/tmi_pkg.sv ***
// Types shared by the timer interrupt block
package tmi_pkg;

    // One bit per interrupt source, in register bit order
    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } tmi_src_t;

    // Strobes and values coming from the counter and waveform logic
    typedef struct packed {
        logic       tick;
        logic       counter_written;
        logic       force_compare_b;
        logic [2:0] wave_gen_mode;
        logic [7:0] counter_value;
        logic [7:0] compare_a_value;
    } tmi_cnt_t;

endpackage

// *** core/tmi_timer_irq.sv ***
// Compare B, interrupt mask and interrupt flag logic of an 8-bit timer, APB slave
`include "tmi_map.svh"

module tmi_timer_irq (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    // Counter side
    input  wire tmi_pkg::tmi_cnt_t i_cnt,
    // Processor core side
    input  wire logic              i_global_irq_en,
    input  wire tmi_pkg::tmi_src_t i_vector_taken,
    output tmi_pkg::tmi_src_t      o_irq_req,
    output logic                   o_irq,
    // Waveform side
    output logic                   o_compare_b_match,
    output logic                   o_compare_a_match
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]        compare_b_value_reg;
    logic [2:0]        timer_irq_mask_reg;
    tmi_pkg::tmi_src_t flags;
    tmi_pkg::tmi_src_t flag_set;
    tmi_pkg::tmi_src_t flag_clr;
    tmi_pkg::tmi_src_t irq_req_reg;
    logic              irq_reg;
    logic              suppress_reg;
    logic              cmp_b_match_reg;
    logic              cmp_a_match_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic [31:0]       prdata_reg;
    logic [31:0]       prdata_next;
    logic              addr_ok;
    logic              setup_phase;
    logic              wr_commit;
    logic              wr_lane0;
    logic              sel_mask;
    logic              sel_flags;
    logic              sel_cmpb;
    logic              eq_b;
    logic              eq_a;
    logic              ovf_point;
    logic              non_pwm_mode;
    logic              cmp_enable;
    logic              access_first;
    logic              read_setup;
    logic              mask_wr;
    logic              cmpb_wr;
    logic              flag_wr;
    logic              at_max;
    logic              at_bottom;
    logic              flag_ovf;
    logic              flag_cmpa;
    logic              flag_cmpb;
    logic              unmasked;
    tmi_pkg::tmi_src_t irq_req_next;

    // ----------------------------------------------------------------
    // APB address decode
    // ----------------------------------------------------------------

    // Register selects from the byte address
    assign sel_mask    = (i_paddr == `TMI_ADDR_OF(`TMI_IDX_MASK));
    assign sel_flags   = (i_paddr == `TMI_ADDR_OF(`TMI_IDX_FLAGS));
    assign sel_cmpb    = (i_paddr == `TMI_ADDR_OF(`TMI_IDX_CMPB));
    assign addr_ok     = sel_mask | sel_flags | sel_cmpb;
    assign setup_phase = i_psel & ~i_penable;

    // A write lands only at the access edge where ready is seen
    assign wr_commit = i_psel & i_penable & pready_reg & i_pwrite & addr_ok;
    assign wr_lane0  = wr_commit & i_pstrb[0]; // Registers live in byte lane 0

    // Per-register write strobes
    assign mask_wr = wr_lane0 & sel_mask;
    assign cmpb_wr = wr_lane0 & sel_cmpb;
    assign flag_wr = wr_lane0 & sel_flags;

    // Setup cycle of a transfer and read setup
    assign access_first = setup_phase & ~pready_reg;
    assign read_setup   = setup_phase & ~i_pwrite;

    // ----------------------------------------------------------------
    // APB answer: one wait-free access phase after setup
    // ----------------------------------------------------------------

    // Read data, reserved bits and upper lanes read as zero
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (sel_mask) begin
            prdata_next[2:0] = timer_irq_mask_reg;
        end else if (sel_flags) begin
            prdata_next[2:0] = flags;
        end else if (sel_cmpb) begin
            prdata_next[7:0] = compare_b_value_reg;
        end
    end

    // Ready rises in the access phase and drops after the taken edge
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access_first;
        end
    end

    // Error answer for an unmapped address, held with ready
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= access_first & ~addr_ok;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (read_setup) begin
            prdata_reg <= prdata_next;
        end else if (!i_psel) begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------

    // Compare value B, full byte
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            compare_b_value_reg <= `TMI_RST_CMPB;
        end else if (cmpb_wr) begin
            compare_b_value_reg <= i_pwdata[7:0];
        end
    end

    // Interrupt mask, only the three enable bits are stored
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            timer_irq_mask_reg <= `TMI_RST_MASK;
        end else if (mask_wr) begin
            timer_irq_mask_reg <= i_pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Compare and overflow detection
    // ----------------------------------------------------------------

    // Equality against both compare values
    assign eq_b = (i_cnt.counter_value == compare_b_value_reg);
    assign eq_a = (i_cnt.counter_value == i_cnt.compare_a_value);

    // Forced compares only act outside the PWM modes
    assign non_pwm_mode = (i_cnt.wave_gen_mode == `TMI_WGM_NORMAL) |
                          (i_cnt.wave_gen_mode == `TMI_WGM_CTC);

    // A timer clock with a counter write, or the first one after it, sees no match
    assign cmp_enable = i_cnt.tick & ~suppress_reg & ~i_cnt.counter_written;

    // Counter landmarks
    assign at_max    = (i_cnt.counter_value == `TMI_CNT_MAX);
    assign at_bottom = (i_cnt.counter_value == `TMI_CNT_BOTTOM);

    // Overflow point for the selected waveform mode
    always_comb begin
        case (i_cnt.wave_gen_mode)
            `TMI_WGM_NORMAL,
            `TMI_WGM_CTC,
            `TMI_WGM_FAST_FIXED: begin
                ovf_point = at_max;
            end
            `TMI_WGM_PC_FIXED,
            `TMI_WGM_PC_VAR: begin
                ovf_point = at_bottom;
            end
            `TMI_WGM_FAST_VAR: begin
                ovf_point = eq_a;
            end
            default: begin
                ovf_point = 1'b0; // Reserved modes raise no overflow
            end
        endcase
    end

    // Arm suppression on a counter write, spend it on the next tick
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            suppress_reg <= 1'b0;
        end else if (i_cnt.counter_written) begin
            suppress_reg <= 1'b1;
        end else if (i_cnt.tick) begin
            suppress_reg <= 1'b0;
        end
    end

    // Match strobe toward the B waveform generator
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cmp_b_match_reg <= 1'b0;
        end else begin
            cmp_b_match_reg <= (cmp_enable & eq_b) |
                               (i_cnt.force_compare_b & non_pwm_mode);
        end
    end

    // Match strobe toward the A waveform generator
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cmp_a_match_reg <= 1'b0;
        end else begin
            cmp_a_match_reg <= cmp_enable & eq_a;
        end
    end

    // ----------------------------------------------------------------
    // Flags: set by events, cleared by vector or write of one
    // ----------------------------------------------------------------

    // Event sets; a forced compare is not among them
    always_comb begin
        flag_set       = '0;
        flag_set.cmp_b = cmp_enable & eq_b;
        flag_set.cmp_a = cmp_enable & eq_a;
        flag_set.ovf   = i_cnt.tick & ovf_point;
    end

    // Clears; a zero written leaves its flag alone
    always_comb begin
        flag_clr       = '0;
        flag_clr.cmp_b = i_vector_taken.cmp_b |
                         (flag_wr & i_pwdata[`TMI_BIT_CMPB]);
        flag_clr.cmp_a = i_vector_taken.cmp_a |
                         (flag_wr & i_pwdata[`TMI_BIT_CMPA]);
        flag_clr.ovf   = i_vector_taken.ovf |
                         (flag_wr & i_pwdata[`TMI_BIT_OVF]);
    end

    // One sticky cell per source
    tmi_flag_cell u_flag_ovf (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (flag_set.ovf),
        .i_clr  (flag_clr.ovf),
        .o_flag (flag_ovf)
    );

    tmi_flag_cell u_flag_cmpa (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (flag_set.cmp_a),
        .i_clr  (flag_clr.cmp_a),
        .o_flag (flag_cmpa)
    );

    tmi_flag_cell u_flag_cmpb (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (flag_set.cmp_b),
        .i_clr  (flag_clr.cmp_b),
        .o_flag (flag_cmpb)
    );

    // Gather the cells into the register view
    assign flags = '{cmp_b: flag_cmpb, cmp_a: flag_cmpa, ovf: flag_ovf};

    // ----------------------------------------------------------------
    // Interrupt requests
    // ----------------------------------------------------------------

    // Per-source request, gated by mask and global enable
    always_comb begin
        irq_req_next.cmp_b = flags.cmp_b & timer_irq_mask_reg[`TMI_BIT_CMPB] &
                             i_global_irq_en;
        irq_req_next.cmp_a = flags.cmp_a & timer_irq_mask_reg[`TMI_BIT_CMPA] &
                             i_global_irq_en;
        irq_req_next.ovf   = flags.ovf & timer_irq_mask_reg[`TMI_BIT_OVF] &
                             i_global_irq_en;
    end

    // Requests to the core, one cycle behind the flags
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            irq_req_reg <= '0;
        end else begin
            irq_req_reg <= irq_req_next;
        end
    end

    // Flags whose enable bit is set, global enable not included
    assign unmasked = |(flags & timer_irq_mask_reg);

    // Summary level: any unmasked flag
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= unmasked;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from flip-flops
    // ----------------------------------------------------------------
    assign o_pready          = pready_reg;
    assign o_pslverr         = pslverr_reg;
    assign o_prdata          = prdata_reg;
    assign o_irq_req         = irq_req_reg;
    assign o_irq             = irq_reg;
    assign o_compare_b_match = cmp_b_match_reg;
    assign o_compare_a_match = cmp_a_match_reg;

endmodule
